// File: hw/rhp_port_power.sv
`timescale 1ns/100ps
// ****************************************************************
// per-port power state keeping
// ****************************************************************
module rhp_port_power
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // command carrier
    rhp_pwr_if.sw     pwr
);
    import rhp_pkg::*;

    logic [NUM_PORTS-1:0] state;             // power per port
    logic [NUM_PORTS-1:0] next_state;        // next power per port

    // ************************************************************
    // next power state, one slice per port
    // ************************************************************
    for (genvar p = 0; p < NUM_PORTS; p++)
    begin : g_port
        logic by_port;                       // port follows own cmds

        // masked port in per-port mode ignores global cmds
        assign by_port = pwr.switch_sel & pwr.mask[p]; // see R01 R03

        always_comb
        begin
            next_state[p] = state[p];
            if (by_port)
            begin
                // own commands only, off wins a tie
                if (pwr.port_off[p])
                    next_state[p] = 1'b0;    // see R01
                else if (pwr.port_on[p])
                    next_state[p] = 1'b1;    // see R01
            end
            else
            begin
                // global commands, off wins a tie
                if (pwr.global_off)
                    next_state[p] = 1'b0;    // see R02 R10
                else if (pwr.global_on)
                    next_state[p] = 1'b1;    // see R02 R09
            end
        end
    end

    // ************************************************************
    // power state registers
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
            state <= RST_PORT_FIELD;
        else
            state <= next_state;
    end

    assign pwr.power_state = state;

endmodule

// File: hw/rhp_root_hub_regs.sv
`timescale 1ns/100ps
// ****************************************************************
// root hub port attribute and hub status registers
// ****************************************************************
// Functional notes
// R01: masked port in per-port mode obeys only per-port power commands
// R02: unmasked port follows global power commands
// R03: global switching mode ignores the mask field
// R04: mask bit0 reserved, bit1 port1, bit2 port2
// R05: fixed flag one means non-removable device
// R06: fixed flags bit0 reserved, bits1-2 ports
// R07: status low half, change bits high half
// R08: software writes reserved bits as zero
// R09: bit16 write one powers eligible ports on
// R10: bit0 write one powers eligible ports off
// R11: overcurrent change sets bit17, write-one clears
// R12: bit15 sets wake enable, bit31 clears
// R13: bits for ports above two read zero
module rhp_root_hub_regs
(
    // clock and reset
    input  wire  logic                          clk,
    input  wire  logic                          rst,
    // register access
    input  wire  logic                          reg_wr,
    input  wire  logic                          reg_rd,
    input  wire  logic [rhp_pkg::ADDR_W-1:0]    reg_addr,
    input  wire  logic [rhp_pkg::DATA_W-1:0]    reg_wdata,
    output logic       [rhp_pkg::DATA_W-1:0]    reg_rdata,
    output logic                                reg_rvalid,
    // switching mode and per-port commands
    input  wire  logic                          power_switch_select,
    input  wire  logic [rhp_pkg::NUM_PORTS-1:0] port_power_on_cmd,
    input  wire  logic [rhp_pkg::NUM_PORTS-1:0] port_power_off_cmd,
    // overcurrent sense pin
    input  wire  logic                          overcurrent_pin,
    // block state
    output logic       [rhp_pkg::NUM_PORTS-1:0] port_power_state,
    output logic                                wake_on_connect_enable,
    output logic                                overcurrent_flag
);
    import rhp_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    logic [NUM_PORTS-1:0] port_power_mask;      // per-port control mask
    logic [NUM_PORTS-1:0] next_port_power_mask; // next mask
    logic [NUM_PORTS-1:0] device_fixed_flags;   // non-removable flags
    logic [NUM_PORTS-1:0] next_device_fixed_flags; // next flags
    logic                 wake_en;              // wake on connect
    logic                 next_wake_en;         // next wake enable
    logic                 oc_change;            // overcurrent change
    logic                 next_oc_change;       // next change flag
    logic                 oc_meta;              // first sync stage
    logic                 oc_sync;              // second sync stage
    logic                 oc_prev;              // last synced level
    logic [DATA_W-1:0]    rdata;                // read data register
    logic [DATA_W-1:0]    next_rdata;           // next read data
    logic                 rvalid;               // read answer pulse

    // ************************************************************
    // decode
    // ************************************************************
    logic                 wr_attr;              // write port attributes
    logic                 wr_status;            // write hub status
    logic                 global_power_on_cmd;  // bit16 write one
    logic                 global_power_off_cmd; // bit0 write one
    logic                 clear_wake_enable_cmd; // bit31 write one
    logic                 set_wake_cmd;         // bit15 write one
    logic                 clear_change_cmd;     // bit17 write one
    logic                 oc_changed;           // synced level moved

    // full-word writes only, no byte lanes
    assign wr_attr   = reg_wr & (reg_addr == OFS_PORT_ATTR);
    assign wr_status = reg_wr & (reg_addr == OFS_HUB_STATUS);

    // write-one command bits of hub status
    assign global_power_on_cmd   = wr_status & reg_wdata[BIT_PWR_ON];
    assign global_power_off_cmd  = wr_status & reg_wdata[BIT_PWR_OFF];
    assign clear_wake_enable_cmd = wr_status & reg_wdata[BIT_WAKE_CLR];
    assign set_wake_cmd          = wr_status & reg_wdata[BIT_WAKE_SET];
    assign clear_change_cmd      = wr_status & reg_wdata[BIT_OC_CHANGE];

    // level change seen only after both sync stages
    assign oc_changed = oc_sync ^ oc_prev;

    // ************************************************************
    // overcurrent synchroniser, two stages then edge history
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            oc_meta <= RST_BIT;
            oc_sync <= RST_BIT;
            oc_prev <= RST_BIT;
        end
        else
        begin
            oc_meta <= overcurrent_pin;
            oc_sync <= oc_meta;
            oc_prev <= oc_sync;
        end
    end

    // ************************************************************
    // next register values
    // ************************************************************
    always_comb
    begin
        next_port_power_mask    = port_power_mask;
        next_device_fixed_flags = device_fixed_flags;
        next_wake_en            = wake_en;
        next_oc_change          = oc_change;

        // only ports one and two are stored, rest dropped
        if (wr_attr)
        begin
            next_port_power_mask =
                reg_wdata[MASK_LSB+PORT1_BIT +: NUM_PORTS];  // see R04 R13
            next_device_fixed_flags =
                reg_wdata[FIXED_LSB+PORT1_BIT +: NUM_PORTS]; // see R05 R06
        end

        // wake enable: set bit, clear bit, clear wins a tie
        if (clear_wake_enable_cmd)
            next_wake_en = 1'b0;                 // see R12
        else if (set_wake_cmd)
            next_wake_en = 1'b1;                 // see R12

        // change flag: hardware set beats software clear
        if (oc_changed)
            next_oc_change = 1'b1;               // see R11
        else if (clear_change_cmd)
            next_oc_change = 1'b0;               // see R11
    end

    // ************************************************************
    // register file
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            port_power_mask    <= RST_PORT_FIELD;
            device_fixed_flags <= RST_PORT_FIELD;
            wake_en            <= RST_BIT;
            oc_change          <= RST_BIT;
        end
        else
        begin
            port_power_mask    <= next_port_power_mask;
            device_fixed_flags <= next_device_fixed_flags;
            wake_en            <= next_wake_en;
            oc_change          <= next_oc_change;
        end
    end

    // ************************************************************
    // read data
    // ************************************************************
    always_comb
    begin
        next_rdata = READ_ZERO;
        if (reg_rd)
        begin
            unique case (reg_addr)
                OFS_PORT_ATTR:
                begin
                    // reserved bit0 and ports above two read zero
                    next_rdata[MASK_LSB+PORT1_BIT +: NUM_PORTS] =
                        port_power_mask;             // see R04 R13
                    next_rdata[FIXED_LSB+PORT1_BIT +: NUM_PORTS] =
                        device_fixed_flags;          // see R06 R13
                end
                OFS_HUB_STATUS:
                begin
                    // status low, change high; commands read zero
                    next_rdata[BIT_OC]        = oc_sync;    // see R07
                    next_rdata[BIT_WAKE_SET]  = wake_en;    // see R07
                    next_rdata[BIT_OC_CHANGE] = oc_change;  // see R07
                end
                default:
                begin
                    // unmapped offset reads zero
                    next_rdata = READ_ZERO;
                end
            endcase
        end
    end

    // ************************************************************
    // read answer registers
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata  <= READ_ZERO;
            rvalid <= RST_BIT;
        end
        else
        begin
            rdata  <= next_rdata;
            rvalid <= reg_rd;
        end
    end

    // ************************************************************
    // port power switching
    // ************************************************************
    rhp_pwr_if pwr ();

    assign pwr.switch_sel = power_switch_select;  // see R03
    assign pwr.global_on  = global_power_on_cmd;  // see R09
    assign pwr.global_off = global_power_off_cmd; // see R10
    assign pwr.mask       = port_power_mask;      // see R01 R02
    assign pwr.port_on    = port_power_on_cmd;
    assign pwr.port_off   = port_power_off_cmd;

    rhp_port_power u_port_power
    (
        .clk (clk),
        .rst (rst),
        .pwr (pwr)
    );

    // ************************************************************
    // outputs
    // ************************************************************
    assign reg_rdata              = rdata;
    assign reg_rvalid             = rvalid;
    assign port_power_state       = pwr.power_state;
    assign wake_on_connect_enable = wake_en;
    assign overcurrent_flag       = oc_sync;

endmodule

// File: pkg/rhp_pkg.sv
// ****************************************************************
// root hub power and status register constants
// ****************************************************************
package rhp_pkg;

    // ************************************************************
    // register bus geometry
    // ************************************************************
    localparam int          ADDR_W      = 8;         // byte address width
    localparam int          DATA_W      = 32;        // register width
    localparam int          NUM_PORTS   = 2;         // downstream ports

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0]  OFS_PORT_ATTR   = 8'h4c; // port attributes
    localparam logic [7:0]  OFS_HUB_STATUS  = 8'h50; // hub status

    // ************************************************************
    // port attribute register fields
    // ************************************************************
    localparam int          FIXED_LSB   = 0;         // fixed flags 15:0
    localparam int          MASK_LSB    = 16;        // power mask 31:16
    localparam int          PORT1_BIT   = 1;         // port 1 in a field

    // ************************************************************
    // hub status register fields
    // ************************************************************
    localparam int          BIT_PWR_OFF     = 0;     // off cmd / reads 0
    localparam int          BIT_OC          = 1;     // overcurrent level
    localparam int          BIT_WAKE_SET    = 15;    // wake enable set
    localparam int          BIT_PWR_ON      = 16;    // on cmd / reads 0
    localparam int          BIT_OC_CHANGE   = 17;    // overcurrent change
    localparam int          BIT_WAKE_CLR    = 31;    // wake enable clear

    // ************************************************************
    // reset values and idle read data
    // ************************************************************
    localparam logic [1:0]  RST_PORT_FIELD  = 2'h0;  // mask / fixed bits
    localparam logic        RST_BIT         = 1'h0;  // single flag bits
    localparam logic [31:0] READ_ZERO       = 32'h0000_0000; // idle bus

endpackage

// File: pkg/rhp_pwr_if.sv
`timescale 1ns/100ps
// ****************************************************************
// power command carrier between register logic and port switches
// ****************************************************************
interface rhp_pwr_if;
    import rhp_pkg::*;

    logic                  switch_sel;       // 0 global, 1 per port
    logic                  global_on;        // global power on pulse
    logic                  global_off;       // global power off pulse
    logic [NUM_PORTS-1:0]  mask;             // per-port control mask
    logic [NUM_PORTS-1:0]  port_on;          // per-port on pulses
    logic [NUM_PORTS-1:0]  port_off;         // per-port off pulses
    logic [NUM_PORTS-1:0]  power_state;      // port power now

    // register side issues commands
    modport regs
    (
        output switch_sel,
        output global_on,
        output global_off,
        output mask,
        output port_on,
        output port_off,
        input  power_state
    );

    // switch side keeps port power
    modport sw
    (
        input  switch_sel,
        input  global_on,
        input  global_off,
        input  mask,
        input  port_on,
        input  port_off,
        output power_state
    );

endinterface

// File: tb/rhp_regs_asserts.sv
`timescale 1ns/100ps
// ****************************************************************
// register bank checker
// ****************************************************************
module rhp_regs_chk
(
    // clock and reset
    input wire logic                          clk,
    input wire logic                          rst,
    // register access
    input wire logic                          reg_wr,
    input wire logic                          reg_rd,
    input wire logic [rhp_pkg::ADDR_W-1:0]    reg_addr,
    input wire logic [rhp_pkg::DATA_W-1:0]    reg_wdata,
    input wire logic [rhp_pkg::DATA_W-1:0]    reg_rdata,
    input wire logic                          reg_rvalid,
    // power and status
    input wire logic                          power_switch_select,
    input wire logic [rhp_pkg::NUM_PORTS-1:0] port_power_on_cmd,
    input wire logic [rhp_pkg::NUM_PORTS-1:0] port_power_off_cmd,
    input wire logic                          overcurrent_pin,
    input wire logic [rhp_pkg::NUM_PORTS-1:0] port_power_state,
    input wire logic                          wake_on_connect_enable,
    input wire logic                          overcurrent_flag
);
    import rhp_pkg::*;

    logic st_wr;                              // write to hub status
    assign st_wr = reg_wr && reg_addr == 8'h50;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // read answer one cycle after the strobe, idle bus reads zero
    a_rvalid_on_read: assert property (reg_rd |=> reg_rvalid)
        else $error("read gave no valid pulse");
    a_rdata_idle: assert property (!reg_rd |=> !reg_rvalid && reg_rdata == 0)
        else $error("read data not idle");
    // unused status bits and write-only commands read zero
    a_status_zeros: assert property (
        reg_rd && reg_addr == 8'h50 |=> (reg_rdata & 32'hfffd_7ffd) == 0)
        else $error("status reserved bits not zero");
    a_attr_zeros: assert property (
        reg_rd && reg_addr == 8'h4c |=> (reg_rdata & 32'hfff9_fff9) == 0)
        else $error("attribute unused bits not zero");
    // wake enable set, clear and hold
    a_wake_set: assert property (
        st_wr && reg_wdata[15] && !reg_wdata[31] |=> wake_on_connect_enable)
        else $error("wake enable not set");
    a_wake_clr: assert property (st_wr && reg_wdata[31] |=>
        !wake_on_connect_enable) else $error("wake enable not cleared");
    a_wake_hold: assert property (
        !(st_wr && (reg_wdata[15] || reg_wdata[31])) |=>
        $stable(wake_on_connect_enable)) else $error("wake enable moved");
    // global switching follows global commands only
    a_global_on: assert property (st_wr && reg_wdata[16] &&
        !reg_wdata[0] && !power_switch_select |=> port_power_state == 2'h3)
        else $error("global power on missed");
    a_global_off: assert property (
        st_wr && reg_wdata[0] && !power_switch_select |=> port_power_state == 0)
        else $error("global power off missed");
    a_global_ignores: assert property (!power_switch_select &&
        !st_wr |=> $stable(port_power_state))
        else $error("per-port command acted in global mode");
    // overcurrent level passes two flops
    a_oc_sync: assert property (
        ##2 overcurrent_flag == $past(overcurrent_pin, 2))
        else $error("overcurrent flag out of step");
endmodule

bind rhp_root_hub_regs rhp_regs_chk u_rhp_regs_chk
(
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .power_switch_select(power_switch_select),
    .port_power_on_cmd(port_power_on_cmd),
    .port_power_off_cmd(port_power_off_cmd),
    .overcurrent_pin(overcurrent_pin), .port_power_state(port_power_state),
    .wake_on_connect_enable(wake_on_connect_enable),
    .overcurrent_flag(overcurrent_flag)
);

// File: tb/testbench.sv
`timescale 1ns/100ps
// ****************************************************************
// register bank testbench
// ****************************************************************
module testbench;
    import rhp_pkg::*;

    logic        clk = 0, rst = 1;            // clock and reset
    logic        reg_wr = 0, reg_rd = 0;      // bus strobes
    logic [7:0]  reg_addr = 0;                // byte address
    logic [31:0] reg_wdata = 0, reg_rdata;    // bus data
    logic        reg_rvalid, sel = 0, oc_pin = 0;
    logic [1:0]  on_cmd = 0, off_cmd = 0, pwr;
    logic        wake, oc_flag;
    int          failures = 0, n_checks = 0;

    rhp_root_hub_regs u_rhp_root_hub_regs
    (
        .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .power_switch_select(sel), .port_power_on_cmd(on_cmd),
        .port_power_off_cmd(off_cmd), .overcurrent_pin(oc_pin),
        .port_power_state(pwr), .wake_on_connect_enable(wake),
        .overcurrent_flag(oc_flag)
    );

    // 100 MHz clock
    initial
    begin
        forever #5 clk = ~clk;
    end

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one-cycle write, then one idle edge; effect visible on return
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr = 0;
        reg_wdata = 0;
        @(posedge clk);
        #1;
    endtask

    // one-cycle read, answer judged while it stands, then idle edge
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        reg_rd = 1;
        reg_addr = a;
        @(posedge clk);
        #1;
        reg_rd = 0;
        chk({31'h0, reg_rvalid}, 32'h1);
        chk(reg_rdata, exp);
        @(posedge clk);
        #1;
    endtask

    // per-port command pulse, then one idle edge
    task automatic pulse(input logic [1:0] on, input logic [1:0] off);
        on_cmd = on;
        off_cmd = off;
        @(posedge clk);
        #1;
        on_cmd = 0;
        off_cmd = 0;
        @(posedge clk);
        #1;
    endtask

    task automatic pst(input logic [1:0] e);
        chk({30'h0, pwr}, {30'h0, e});
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset_vals;
        rd(8'h4c, 32'h0);
        rd(8'h50, 32'h0);
        chk({28'h0, pwr, wake, oc_flag}, 32'h0);
    endtask

    task automatic t_attr_bits;
        wr(8'h4c, 32'hffff_ffff);
        rd(8'h4c, 32'h0006_0006);
        rd(8'h54, 0);
        wr(8'h4c, 0);
        rd(8'h4c, 0);
    endtask

    task automatic t_global_mode;
        sel = 0;
        wr(8'h4c, 32'h0006_0000);
        wr(8'h50, 32'h0001_0000);
        pst(2'h3);
        pulse(0, 2'h3);
        pst(2'h3);
        rd(8'h50, 0);
        wr(8'h50, 32'h0000_0001);
        pst(2'h0);
    endtask

    task automatic t_per_port;
        sel = 1;
        wr(8'h4c, 32'h0002_0000);
        wr(8'h50, 32'h0001_0000);
        pst(2'h2);
        pulse(2'h1, 0);
        pst(2'h3);
        wr(8'h50, 32'h0000_0001);
        pst(2'h1);
        pulse(0, 2'h2);
        pst(2'h1);
        pulse(0, 2'h1);
        pst(2'h0);
    endtask

    task automatic t_wake;
        wr(8'h50, 32'h0000_8000);
        rd(8'h50, 32'h0000_8000);
        wr(8'h50, 0);
        chk({31'h0, wake}, 32'h1);
        wr(8'h50, 32'h8000_0000);
        rd(8'h50, 0);
    endtask

    task automatic t_overcurrent;
        oc_pin = 1;
        repeat (4) @(posedge clk);
        #1;
        chk({31'h0, oc_flag}, 32'h1);
        rd(8'h50, 32'h0002_0002);
        wr(8'h50, 32'h0002_0000);
        rd(8'h50, 32'h0000_0002);
        oc_pin = 0;
        repeat (4) @(posedge clk);
        #1;
        chk({31'h0, oc_flag}, 32'h0);
        rd(8'h50, 32'h0002_0000);
        wr(8'h50, 32'h0002_0000);
        rd(8'h50, 0);
    endtask

    // verdict and end of run
    task automatic close_out;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // watchdog
    initial
    begin
        #20000;
        failures++;
        close_out;
    end

    // main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        #1 rst = 0;
        t_reset_vals;
        t_attr_bits;
        t_global_mode;
        t_per_port;
        t_wake;
        t_overcurrent;
        close_out;
    end
endmodule
